//--- src/ppc_defs.svh
// Constants of the parallel port option configuration block
// Assumes inclusion by bare name from any file of the block
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH

// Register byte offsets
`define PPC_OFS_CFG       12'h000
`define PPC_OFS_PRN       12'h004
`define PPC_OFS_DATA      12'h008
`define PPC_OFS_STAT      12'h00C

// Switch positions in dip_sw (bit index = switch number - 1)
`define PPC_SW_COMPAT     0
`define PPC_SW_SELFTEST   1
`define PPC_SW_RISE       2
`define PPC_SW_SELECT_STATUS_OUT_LIVE  3
`define PPC_SW_CONT       4

// Field positions
`define PPC_CFG_CARD_EN   8
`define PPC_CFG_DONE      9
`define PPC_PRN_SEL       0
`define PPC_PRN_ERR       1
`define PPC_DATA_FULL     8
`define PPC_ST_NIBBLE     0
`define PPC_ST_SELFTEST   1
`define PPC_ST_ACTIVE     2
`define PPC_ST_SELECT_STATUS_OUT       3

// Reset values
`define PPC_PRN_RST       2'h0
`define PPC_DATA_RST      8'h00

// Self test sheet count when not continuous
`define PPC_TEST_SHEETS   4'h2

`endif

//--- src/ppc_pkg.sv
// Types of the parallel port option configuration block
// Assumes ppc_defs.svh carries the numeric constants
package ppc_pkg;

  // Switch settings as captured at power-up
  typedef struct packed {
    logic card_en;
    logic cont;
    logic select_status_out_live;
    logic latch_rise;
    logic self_test;
    logic compat_fixed;
  } ppc_cfg_t;

  // Capture sequencer states
  typedef enum logic [1:0] {
    PPC_CAP_WAIT,
    PPC_CAP_TAKE,
    PPC_CAP_DONE
  } ppc_cap_state_t;

endpackage

//--- src/ppc_sw_capture.sv
// Power-up capture of the DIP and slide switches
// Assumes switches are static levels synchronous to pclk
`timescale 1ns/1ps
`include "ppc_defs.svh"

module ppc_sw_capture (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Switch pins
  input  wire logic [7:0]       dip_sw,
  input  wire logic             card_en_sw,
  // Captured settings
  output ppc_pkg::ppc_cfg_t     cfg,
  output logic                  cap_done
);

  ppc_pkg::ppc_cap_state_t state_ff;
  ppc_pkg::ppc_cap_state_t nxt_state;
  ppc_pkg::ppc_cfg_t       cfg_ff;

  always_comb begin
    case (state_ff)
      ppc_pkg::PPC_CAP_WAIT: nxt_state = ppc_pkg::PPC_CAP_TAKE;
      ppc_pkg::PPC_CAP_TAKE: nxt_state = ppc_pkg::PPC_CAP_DONE;
      ppc_pkg::PPC_CAP_DONE: nxt_state = ppc_pkg::PPC_CAP_DONE;
      default:               nxt_state = ppc_pkg::PPC_CAP_WAIT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ppc_pkg::PPC_CAP_WAIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Switches taken once after release, frozen thereafter
  // Positions six to eight never sampled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= '0;
    end else if (state_ff == ppc_pkg::PPC_CAP_TAKE) begin
      cfg_ff.compat_fixed <= dip_sw[`PPC_SW_COMPAT];
      cfg_ff.self_test    <= dip_sw[`PPC_SW_SELFTEST];
      cfg_ff.latch_rise   <= dip_sw[`PPC_SW_RISE];
      cfg_ff.select_status_out_live    <= dip_sw[`PPC_SW_SELECT_STATUS_OUT_LIVE];
      cfg_ff.cont         <= dip_sw[`PPC_SW_CONT];
      cfg_ff.card_en      <= card_en_sw;
    end
  end

  assign cfg      = cfg_ff;
  assign cap_done = (state_ff == ppc_pkg::PPC_CAP_DONE);

  chk_cfg_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    cap_done && $past(cap_done) |-> $stable(cfg_ff))
    else $error("Captured switch settings changed after power-up");

endmodule

//--- src/ppc_top.sv
// Parallel port option card configuration logic with APB registers
// Assumes link pins synchronous to pclk; host handles 1284 negotiation
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ppc_defs.svh"

module ppc_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Switches
  input  wire logic [7:0]  dip_sw,
  input  wire logic        card_en_sw,
  // Host link
  input  wire logic        strobe_n,
  input  wire logic [7:0]  fwd_data,
  input  wire logic        select_request_in,
  input  wire logic        host_nibble_req,
  output logic             select_status_out,
  // Printer side
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  output logic             nibble_mode,
  output logic             self_test_active,
  output logic             self_test_continuous,
  output logic [3:0]       self_test_sheets,
  output logic             card_active
);

  ppc_pkg::ppc_cfg_t cfg;
  logic              cap_done;
  logic              strobe_prev_ff;
  logic              strobe_fall;
  logic              strobe_rise;
  logic              latch_edge;
  logic [1:0]        prn_ff;
  logic [7:0]        data_ff;
  logic              full_ff;
  logic              rx_valid_ff;
  logic              nibble_ff;
  logic              select_status_out_ff;
  logic              wr_en;
  logic              rd_en;
  logic              addr_ok;
  logic              data_rd;
  logic [31:0]       nxt_prdata;
  logic [31:0]       prdata_ff;
  logic              operating;

  ppc_sw_capture u_cap (
    .pclk       (pclk),
    .presetn    (presetn),
    .dip_sw     (dip_sw),
    .card_en_sw (card_en_sw),
    .cfg        (cfg),
    .cap_done   (cap_done)
  );

  // Card enable gates all link activity, select_status_out only when select is live; otherwise select_status_out stays forced high
  assign card_active = cap_done && cfg.card_en;
  // Self test replaces normal operation
  assign operating   = card_active && !cfg.self_test;

  // Self test selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_test_active     <= 1'b0;
      self_test_continuous <= 1'b0;
      self_test_sheets     <= 4'h0;
    end else begin
      self_test_active     <= card_active && cfg.self_test;
      self_test_continuous <= card_active && cfg.self_test && cfg.cont;
      self_test_sheets     <= (card_active && cfg.self_test && !cfg.cont) ?
                              `PPC_TEST_SHEETS : 4'h0;
    end
  end

  // Mode choice: fixed compatibility or negotiated nibble
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nibble_ff <= 1'b0;
    end else begin
      nibble_ff <= operating && !cfg.compat_fixed && host_nibble_req;
    end
  end
  assign nibble_mode = nibble_ff;

  // Strobe edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_prev_ff <= 1'b1;
    end else begin
      strobe_prev_ff <= strobe_n;
    end
  end
  assign strobe_fall = strobe_prev_ff && !strobe_n;
  assign strobe_rise = !strobe_prev_ff && strobe_n;
  // Latch edge chosen by switch three
  assign latch_edge  = operating && (cfg.latch_rise ? strobe_rise : strobe_fall);

  // Forward data latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ff     <= `PPC_DATA_RST;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= latch_edge;
      if (latch_edge) begin
        data_ff <= fwd_data;
      end
    end
  end
  assign rx_data  = data_ff;
  assign rx_valid = rx_valid_ff;

  // Byte-held flag: a new byte wins over a read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_ff <= 1'b0;
    end else if (latch_edge) begin
      full_ff <= 1'b1;
    end else if (data_rd) begin
      full_ff <= 1'b0;
    end
  end

  // Select status: forced high or live printer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      select_status_out_ff <= 1'b1;
    end else if (!cap_done || !cfg.select_status_out_live) begin
      select_status_out_ff <= 1'b1;
    end else begin
      select_status_out_ff <= card_active && prn_ff[`PPC_PRN_SEL] && !prn_ff[`PPC_PRN_ERR] &&
                 !select_request_in;
    end
  end
  assign select_status_out = select_status_out_ff;

  // APB decode, zero wait states
  assign pready  = 1'b1;
  assign addr_ok = (paddr == `PPC_OFS_CFG) || (paddr == `PPC_OFS_PRN) ||
                   (paddr == `PPC_OFS_DATA) || (paddr == `PPC_OFS_STAT);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !penable && !pwrite;
  assign data_rd = psel && penable && !pwrite && (paddr == `PPC_OFS_DATA);

  // Printer status written by firmware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prn_ff <= `PPC_PRN_RST;
    end else if (wr_en && paddr == `PPC_OFS_PRN) begin
      prn_ff <= pwdata[1:0];
    end
  end

  // Read mux, upper switch positions read zero
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      `PPC_OFS_CFG: begin
        nxt_prdata[`PPC_SW_COMPAT]    = cfg.compat_fixed;
        nxt_prdata[`PPC_SW_SELFTEST]  = cfg.self_test;
        nxt_prdata[`PPC_SW_RISE]      = cfg.latch_rise;
        nxt_prdata[`PPC_SW_SELECT_STATUS_OUT_LIVE] = cfg.select_status_out_live;
        nxt_prdata[`PPC_SW_CONT]      = cfg.cont;
        nxt_prdata[`PPC_CFG_CARD_EN]  = cfg.card_en;
        nxt_prdata[`PPC_CFG_DONE]     = cap_done;
      end
      `PPC_OFS_PRN: begin
        nxt_prdata[1:0] = prn_ff;
      end
      `PPC_OFS_DATA: begin
        nxt_prdata[7:0]            = data_ff;
        nxt_prdata[`PPC_DATA_FULL] = full_ff;
      end
      `PPC_OFS_STAT: begin
        nxt_prdata[`PPC_ST_NIBBLE]   = nibble_ff;
        nxt_prdata[`PPC_ST_SELFTEST] = self_test_active;
        nxt_prdata[`PPC_ST_ACTIVE]   = card_active;
        nxt_prdata[`PPC_ST_SELECT_STATUS_OUT]     = select_status_out_ff;
      end
      default: begin
        nxt_prdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata_ff <= nxt_prdata;
    end
  end
  assign prdata = prdata_ff;

  chk_nibble_gate: assert property (@(posedge pclk) disable iff (!presetn)
    nibble_ff |-> $past(!cfg.compat_fixed && host_nibble_req && operating))
    else $error("Nibble mode entered without negotiation or with fixed mode");

  chk_fall_latch: assert property (@(posedge pclk) disable iff (!presetn)
    operating && !cfg.latch_rise && strobe_prev_ff && !strobe_n
    |=> rx_valid && rx_data == $past(fwd_data))
    else $error("Falling strobe edge did not latch data");

  chk_rise_latch: assert property (@(posedge pclk) disable iff (!presetn)
    operating && cfg.latch_rise && !strobe_prev_ff && strobe_n
    |=> rx_valid && rx_data == $past(fwd_data))
    else $error("Rising strobe edge did not latch data");

  chk_select_status_out_forced: assert property (@(posedge pclk) disable iff (!presetn)
    cap_done && !cfg.select_status_out_live |=> select_status_out)
    else $error("Select output not held high while forced");

  chk_select_status_out_live: assert property (@(posedge pclk) disable iff (!presetn)
    card_active && cfg.select_status_out_live ##1 card_active
    |-> select_status_out == $past(prn_ff[0] && !prn_ff[1] && !select_request_in))
    else $error("Select output does not follow printer state");

  chk_disabled_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !card_active |=> !rx_valid && !nibble_mode && !self_test_active)
    else $error("Disabled card took part in communication");

  chk_test_sheets: assert property (@(posedge pclk) disable iff (!presetn)
    card_active && cfg.self_test && !cfg.cont |=> self_test_sheets == 4'h2)
    else $error("Self test sheet count wrong");

  chk_test_no_rx: assert property (@(posedge pclk) disable iff (!presetn)
    self_test_active |-> !rx_valid)
    else $error("Data latched during self test");

  chk_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && paddr == `PPC_OFS_CFG |-> prdata[7:5] == 3'h0)
    else $error("Unused switch positions visible");

  cov_nibble: cover property (@(posedge pclk) disable iff (!presetn) $rose(nibble_mode));
  cov_rx:     cover property (@(posedge pclk) disable iff (!presetn) rx_valid);
  cov_test:   cover property (@(posedge pclk) disable iff (!presetn) self_test_continuous);

endmodule

//--- bench/ppc_host_model.sv
// Host side model of the parallel link
// Assumes the bench calls its tasks just after a rising pclk edge
`timescale 1ns/1ps

module ppc_host_model (
  // Clock
  input  wire logic       pclk,
  // Host link
  output logic            strobe_n,
  output logic [7:0]      fwd_data,
  output logic            select_request_in,
  output logic            host_nibble_req
);
  initial begin
    strobe_n          = 1'b1;
    fwd_data          = 8'h00;
    select_request_in = 1'b0;
    host_nibble_req   = 1'b0;
  end

  // Static host lines
  task automatic set_lines(input logic sel_in, input logic nib);
    select_request_in <= sel_in;
    host_nibble_req   <= nib;
  endtask

  // One strobe pulse, data differs at each edge, levels held 3 cycles
  task automatic send(input logic [7:0] d_fall, input logic [7:0] d_rise);
    @(posedge pclk);
    fwd_data <= d_fall;
    strobe_n <= 1'b0;
    repeat (3) @(posedge pclk);
    fwd_data <= d_rise;
    strobe_n <= 1'b1;
    repeat (3) @(posedge pclk);
    fwd_data <= ~d_rise;
  endtask
endmodule

//--- bench/parallel_port_option_config_test.sv
// Bench of the option card configuration block
// Assumes ppc_top with APB slave; host link driven by ppc_host_model
`timescale 1ns/1ps
`include "ppc_defs.svh"

module parallel_port_option_config_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  dip_sw, fwd_data, rx_data;
  logic        card_en_sw, strobe_n, select_request_in, host_nibble_req;
  logic        select_status_out, rx_valid, nibble_mode, card_active;
  logic        self_test_active, self_test_continuous;
  logic [3:0]  self_test_sheets;
  int          fail_count, num_checks, rx_cnt;

  ppc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dip_sw(dip_sw), .card_en_sw(card_en_sw), .strobe_n(strobe_n),
    .fwd_data(fwd_data), .select_request_in(select_request_in),
    .host_nibble_req(host_nibble_req), .select_status_out(select_status_out),
    .rx_data(rx_data), .rx_valid(rx_valid), .nibble_mode(nibble_mode),
    .self_test_active(self_test_active), .self_test_continuous(self_test_continuous),
    .self_test_sheets(self_test_sheets), .card_active(card_active));

  ppc_host_model host (.pclk(pclk), .strobe_n(strobe_n), .fwd_data(fwd_data),
    .select_request_in(select_request_in), .host_nibble_req(host_nibble_req));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Latched byte counter, cleared by each reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cnt <= 0;
    end else if (rx_valid === 1'b1) begin
      rx_cnt <= rx_cnt + 1;
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string name);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check(name, rd, exp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic power_up(input logic [7:0] sw, input logic en);
    @(posedge pclk);
    presetn    <= 1'b0;
    dip_sw     <= sw;
    card_en_sw <= en;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
  endtask

  initial begin
    logic [31:0] rd;
    logic        err;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    dip_sw = 8'h00;
    card_en_sw = 1'b1;
    fail_count = 0;
    num_checks = 0;
    // Default switches, auto mode, falling edge, select forced
    power_up(8'h00, 1'b1);
    rchk(`PPC_OFS_CFG, 32'h0000_0300, "cfg");
    check("nibble", 32'(nibble_mode), 32'h0000_0000);
    host.set_lines(1'b1, 1'b1);
    wr(`PPC_OFS_PRN, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    check("select_status_out", 32'(select_status_out), 32'h0000_0001);
    check("nibble", 32'(nibble_mode), 32'h0000_0001);
    host.send(8'hA5, 8'h5A);
    check("rx_data", 32'(rx_data), 32'h0000_00A5);
    check("rx_cnt", 32'(rx_cnt), 32'h0000_0001);
    rchk(`PPC_OFS_DATA, 32'h0000_01A5, "data");
    rchk(`PPC_OFS_STAT, 32'h0000_000D, "stat");
    apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
    check("unmapped", {31'h0, err}, 32'h0000_0001);
    $display("test 1 done");
    // Fixed compat, rising edge, live select, unused switches on
    power_up(8'hED, 1'b1);
    host.set_lines(1'b0, 1'b1);
    rchk(`PPC_OFS_CFG, 32'h0000_030D, "cfg");
    check("nibble", 32'(nibble_mode), 32'h0000_0000);
    host.send(8'h3C, 8'hC3);
    check("rx_data", 32'(rx_data), 32'h0000_00C3);
    wr(`PPC_OFS_PRN, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    check("select_status_out", 32'(select_status_out), 32'h0000_0001);
    host.set_lines(1'b1, 1'b1);
    repeat (3) @(posedge pclk);
    check("select_status_out", 32'(select_status_out), 32'h0000_0000);
    host.set_lines(1'b0, 1'b1);
    wr(`PPC_OFS_PRN, 32'h0000_0003);
    repeat (3) @(posedge pclk);
    check("select_status_out", 32'(select_status_out), 32'h0000_0000);
    rchk(`PPC_OFS_PRN, 32'h0000_0003, "prn");
    dip_sw     <= 8'h00;
    card_en_sw <= 1'b0;
    repeat (5) @(posedge pclk);
    rchk(`PPC_OFS_CFG, 32'h0000_030D, "cfg");
    check("active", 32'(card_active), 32'h0000_0001);
    $display("test 2 done");
    // Self test, two sheets then continuous
    for (int i = 0; i < 2; i++) begin
      power_up(i ? 8'h12 : 8'h02, 1'b1);
      check("selftest", 32'({self_test_active, self_test_continuous, self_test_sheets}),
            32'({1'b1, i[0], i ? 4'h0 : 4'h2}));
    end
    $display("test 3 done");
    // Card disabled
    power_up(8'h00, 1'b0);
    check("active", 32'(card_active), 32'h0000_0000);
    host.send(8'h81, 8'h18);
    check("rx_cnt", 32'(rx_cnt), 32'h0000_0000);
    check("select_status_out", 32'(select_status_out), 32'h0000_0001);
    // Card disabled with live select: select output low
    power_up(8'h08, 1'b0);
    wr(`PPC_OFS_PRN, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    check("select_status_out", 32'(select_status_out), 32'h0000_0000);
    rchk(`PPC_OFS_STAT, 32'h0000_0000, "stat");
    $display("test 4 done");
    summarize();
  end
endmodule
